//--- dv/slp_far_end.sv
// far end model: stalling character sink and character source
`default_nettype none
module slp_far_end (
  // clock
  input  wire logic       clk_i,
  // characters from the controller
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // characters to the controller
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int         seed = 32'h13a667eb;
  initial begin
    tx_ready_o = 1'b0;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_err_o = 1'b0;
  end
  // random stalls keep held characters under test
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    tx_ready_o <= ($random(seed) & 3) != 0;
  end
  // characters go out back to back, well inside the gap time
  task automatic send(input logic [7:0] b, input logic e);
    @(posedge clk_i);
    rx_data_o <= b;
    rx_valid_o <= 1'b1;
    rx_err_o <= e;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_err_o <= 1'b0;
    rx_data_o <= ~b;
  endtask
endmodule
`default_nettype wire

//--- dv/slp_link_ctrl_props.sv
// port assertions for the link controller
`default_nettype none
module slp_link_ctrl_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_nak: assert property ($fell(rst_i) |-> ##[0:1] (tx_valid_o && tx_data_o == slp_pkg::CH_NAK))
    else $error("no nak after reset");
  chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack has no cause");
  chk_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("character dropped while held");
  chk_tx_bubble: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no bubble after accept");
endmodule
bind slp_link_ctrl slp_link_ctrl_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
`default_nettype wire

//--- dv/slp_link_ctrl_tb_top.sv
// self-checking bench for the link controller
`default_nettype none
module slp_link_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, req, we, rx_valid, rx_err, tx_valid, tx_ready, ack;
  logic [7:0]  adr, rx_data, tx_data, bcc, b;
  logic [31:0] wdat, rdat, rd;
  logic [7:0]  exp_q [5];
  int          fail_count, samples_checked, seed = 32'h13a667eb;
  slp_link_ctrl #(.CYC_PER_MS(4), .DEPTH(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rd),
    .wb_ack_o(ack), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_err_i(rx_err));
  slp_far_end i_far (.clk_i(clk_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_err_o(rx_err));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task conclude;
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      conclude;
    end
    rdat = rd;
    req <= 1'b0;
  endtask
  // waits for the next accepted character and folds it into the check byte
  task automatic expc(input logic [7:0] e);
    int n;
    n = 0;
    while (i_far.got.size() == 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      conclude;
    end
    chk({24'h0, i_far.got.pop_front()}, {24'h0, e});
    bcc = bcc ^ e;
  endtask
  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    bcc = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    expc(slp_pkg::CH_NAK);
    // short timeouts: ack 20 ms, gap 10 ms; 2 attempts, 2 frames, 5 bytes
    wb(1'b1, slp_pkg::ADR_CFG0, {16'd10, 16'd20});
    wb(1'b1, slp_pkg::ADR_CFG1, 32'h0000_0522);
    for (int i = 0; i < 5; i++) begin
      exp_q[i] = (i == 1) ? slp_pkg::CH_DLE : 8'($random(seed));
      wb(1'b1, 8'(8'h40 + 4 * i), {24'h0, exp_q[i]});
    end
    wb(1'b1, slp_pkg::ADR_CTRL, 32'h3);
    expc(slp_pkg::CH_STX);
    i_far.send(slp_pkg::CH_DLE, 1'b0);
    bcc = 8'h00;
    for (int i = 0; i < 5; i++) begin
      expc(exp_q[i]);
      if (exp_q[i] == slp_pkg::CH_DLE)
        expc(slp_pkg::CH_DLE);
    end
    expc(slp_pkg::CH_DLE);
    expc(slp_pkg::CH_ETX);
    expc(bcc);
    i_far.send(slp_pkg::CH_DLE, 1'b0);
    wb(1'b0, slp_pkg::ADR_STAT, 32'h0);
    chk(rdat & 32'h0000_ff03, 32'h0000_0002);
    // receive three bytes, one of them doubled on the line
    i_far.send(slp_pkg::CH_STX, 1'b0);
    expc(slp_pkg::CH_DLE);
    bcc = 8'h00;
    for (int i = 0; i < 3; i++) begin
      b = (i == 1) ? slp_pkg::CH_DLE : 8'($random(seed));
      exp_q[i] = b;
      i_far.send(b, 1'b0);
      if (b == slp_pkg::CH_DLE)
        i_far.send(b, 1'b0);
      else
        bcc = bcc ^ b;
    end
    i_far.send(slp_pkg::CH_DLE, 1'b0);
    i_far.send(slp_pkg::CH_ETX, 1'b0);
    i_far.send(bcc ^ slp_pkg::CH_DLE ^ slp_pkg::CH_ETX, 1'b0);
    bcc = 8'h00;
    expc(slp_pkg::CH_DLE);
    wb(1'b0, slp_pkg::ADR_STAT, 32'h0);
    chk(rdat & 32'h00ff_0004, 32'h0003_0004);
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, 8'(8'h80 + 4 * i), 32'h0);
      chk(rdat & 32'h0000_00ff, {24'h0, exp_q[i]});
    end
    wb(1'b1, slp_pkg::ADR_CTRL, 32'h8);
    i_far.send(8'h41, 1'b0);
    expc(slp_pkg::CH_NAK);
    wb(1'b0, slp_pkg::ADR_STAT, 32'h0);
    chk(rdat & 32'h0000_ff00, {16'h0, slp_pkg::ERR_IDLE_CHAR, 8'h0});
    wb(1'b1, slp_pkg::ADR_CTRL, 32'h10);
    // partner refuses every connection request
    wb(1'b1, slp_pkg::ADR_CTRL, 32'h1);
    repeat (2) begin
      expc(slp_pkg::CH_STX);
      i_far.send(slp_pkg::CH_NAK, 1'b0);
    end
    expc(slp_pkg::CH_NAK);
    wb(1'b0, slp_pkg::ADR_STAT, 32'h0);
    chk(rdat & 32'h0000_ff00, {16'h0, slp_pkg::ERR_CONN, 8'h0});
    // partner aborts every frame with NAK right after the first byte
    wb(1'b1, 8'h40, 32'h7e);
    wb(1'b1, slp_pkg::ADR_CTRL, 32'h11);
    repeat (2) begin
      expc(slp_pkg::CH_STX);
      i_far.send(slp_pkg::CH_DLE, 1'b0);
      i_far.send(slp_pkg::CH_NAK, 1'b0);
      expc(8'h7e);
    end
    expc(slp_pkg::CH_NAK);
    wb(1'b0, slp_pkg::ADR_STAT, 32'h0);
    chk(rdat & 32'h0000_ff01, {16'h0, slp_pkg::ERR_TX_REP, 8'h0});
    conclude;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire

//--- hw/slp_link_ctrl.sv
// link procedure controller: send and receive state machine with wishbone registers
//
// Local design decisions: the address map and register access over Wishbone.
`default_nettype none
// Functional notes
// - send job starts with STX; data follows only on DLE before ack timeout
// - NAK, other character or ack timeout repeats the connection request
// - after configured failed attempts send NAK and report connection error
// - frame characters go back to back; receiver checks every gap
// - payload byte equal to DLE is sent twice
// - payload followed by DLE ETX, check byte in checksum variant, then await ack
// - check byte is XOR of doubled stream after STX through DLE ETX
// - DLE after frame end is success; anything else restarts from STX
// - after configured repetitions abandon job, send NAK, report error
// - NAK while sending aborts the frame and repeats from STX without sending NAK
// - other character while sending: wait gap timeout, send NAK, restart STX
// - without pending job stay idle waiting for partner connection
// - idle non-STX non-NAK character: wait gap timeout, send NAK, report error
// - STX with free buffer: reply DLE, store characters, undouble DLE pairs
// - buffer full before frame end ends the connection with NAK
// - character gap timeout in reception sends NAK and reports error
// - basic variant ends on DLE ETX, answers DLE and returns idle, or NAK and awaits repeat
// - checksum variant compares check byte; match gives DLE, else NAK and repeat
// - no free buffer on STX: wait 400 ms, then DLE or error NAK idle
// - faulty character in reception: receive to frame end, then NAK
// - abandon reception after configured repeats or no repeat within 4 s
// - one NAK is sent right after reset
// - simultaneous STX: low priority side yields and acknowledges with DLE
// - character framing is done by the line serializer outside this block
module slp_link_ctrl #(
  parameter int CYC_PER_MS = slp_pkg::CYC_PER_MS,
  parameter int DEPTH      = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // character transmitter
  output logic [7:0]       tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // character receiver
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_err_i
);
  localparam int IW = $clog2(DEPTH + 1);
  localparam logic [IW-1:0] IDX_FULL = IW'(DEPTH);

  function automatic logic [31:0] wb_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    return r;
  endfunction

  // registers
  slp_pkg::slp_state_e state_q, state_d;
  slp_pkg::slp_cfg_s   cfg_q, cfg_d;
  logic [31:0]   cfg0_q, cfg1_q, ctrl_q;
  logic [7:0]    txbuf [DEPTH];
  logic [7:0]    rxbuf [DEPTH];
  logic [7:0]    txd_q, txd_d, bcc_q, bcc_d, err_q, rlen_q;
  logic          txp_q, txp_d, bad_q, bad_d, dle_q, dle_d;
  logic          job_q, done_q, rxfull_q, ack_q;
  logic [IW-1:0] idx_q, idx_d;
  logic [3:0]    conn_q, conn_d, rep_q, rep_d;
  // fsm strobes
  logic          tmr_load, rx_we, job_clr, done_set, rxfull_set;
  logic [15:0]   tmr_ms;
  logic [7:0]    err_code;
  // bus decode
  logic          wb_req, wb_wr, wr_ctrl, wr_cfg0, wr_cfg1, wr_txb;
  logic [31:0]   ctrl_w, rd_mux, stat_w;
  logic          tick, tmo;
  logic [7:0]    c, tx_byte;
  logic          rep_last, conn_last;

  slp_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  slp_ms_timer u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .load_i    (tmr_load),
    .ms_i      (tmr_ms),
    .expired_o (tmo)
  );

  // wishbone decode, one wait state
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr   = wb_req && wb_we_i;
  assign wr_ctrl = wb_wr && wb_adr_i == slp_pkg::ADR_CTRL;
  assign wr_cfg0 = wb_wr && wb_adr_i == slp_pkg::ADR_CFG0;
  assign wr_cfg1 = wb_wr && wb_adr_i == slp_pkg::ADR_CFG1;
  assign wr_txb  = wb_wr && wb_adr_i[7:6] == slp_pkg::BANK_TXBUF && wb_sel_i[0];
  assign ctrl_w  = wb_merge(ctrl_q, wb_dat_i, wb_sel_i);
  assign stat_w  = {8'h0, rlen_q, err_q, 5'h0, rxfull_q, done_q, job_q};
  assign wb_ack_o = ack_q;

  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr_i[7:6])
      2'h0: begin
        if (wb_adr_i == slp_pkg::ADR_CTRL) rd_mux = {30'h0, ctrl_q[1:0] & 2'h2};
        else if (wb_adr_i == slp_pkg::ADR_CFG0) rd_mux = cfg0_q;
        else if (wb_adr_i == slp_pkg::ADR_CFG1) rd_mux = cfg1_q;
        else if (wb_adr_i == slp_pkg::ADR_STAT) rd_mux = stat_w;
      end
      slp_pkg::BANK_TXBUF: rd_mux = {24'h0, txbuf[wb_adr_i[5:2]]};
      slp_pkg::BANK_RXBUF: rd_mux = {24'h0, rxbuf[wb_adr_i[5:2]]};
      2'h3: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_q   <= 32'h0;
      cfg0_q   <= {slp_pkg::RST_GAP_MS, slp_pkg::RST_ACK_MS};
      cfg1_q   <= {24'h0, slp_pkg::RST_REPEATS, slp_pkg::RST_ATTEMPTS};
    end else begin
      ack_q    <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
      if (wr_ctrl) ctrl_q <= ctrl_w & 32'h6;
      if (wr_cfg0) cfg0_q <= wb_merge(cfg0_q, wb_dat_i, wb_sel_i);
      if (wr_cfg1) cfg1_q <= wb_merge(cfg1_q, wb_dat_i, wb_sel_i) & 32'hffff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_txb) txbuf[wb_adr_i[5:2]] <= wb_dat_i[7:0];
    if (rx_we) rxbuf[idx_q[IW-2:0]] <= c;
  end

  // sticky flags: the hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      job_q    <= 1'b0;
      done_q   <= 1'b0;
      rxfull_q <= 1'b0;
      err_q    <= slp_pkg::ERR_NONE;
    end else begin
      if (wr_ctrl && ctrl_w[slp_pkg::CTRL_START]) job_q <= 1'b1;
      else if (job_clr) job_q <= 1'b0;
      if (done_set) done_q <= 1'b1;
      else if (wr_ctrl && ctrl_w[slp_pkg::CTRL_START]) done_q <= 1'b0;
      if (rxfull_set) rxfull_q <= 1'b1;
      else if (wr_ctrl && ctrl_w[slp_pkg::CTRL_RXREL]) rxfull_q <= 1'b0;
      // only the first error is kept until cleared
      if (wr_ctrl && ctrl_w[slp_pkg::CTRL_ERRCLR]) err_q <= err_code;
      else if (err_q == slp_pkg::ERR_NONE) err_q <= err_code;
    end
  end

  assign c         = rx_data_i;
  assign tx_byte   = txbuf[idx_q[IW-2:0]];
  assign tx_data_o = txd_q;
  assign tx_valid_o = txp_q;
  assign rep_last  = (5'(rep_q) + 5'h1) >= 5'(cfg_q.repeats);
  assign conn_last = (5'(conn_q) + 5'h1) >= 5'(cfg_q.attempts);

  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    txd_d = txd_q;
    txp_d = txp_q && !tx_ready_i;
    bcc_d = bcc_q;
    bad_d = bad_q;
    dle_d = dle_q;
    idx_d = idx_q;
    conn_d = conn_q;
    rep_d = rep_q;
    tmr_load = 1'b0;
    tmr_ms = cfg_q.gap_ms;
    rx_we = 1'b0;
    job_clr = 1'b0;
    done_set = 1'b0;
    rxfull_set = 1'b0;
    err_code = slp_pkg::ERR_NONE;
    unique case (state_q)
      slp_pkg::S_RST_NAK: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_NAK;
        state_d = slp_pkg::S_IDLE;
      end
      slp_pkg::S_IDLE: begin
        cfg_d = {cfg0_q[15:0], cfg0_q[31:16], cfg1_q[3:0], cfg1_q[7:4],
                 ctrl_q[slp_pkg::CTRL_CHK], ctrl_q[slp_pkg::CTRL_HIPRIO]};
        rep_d = 4'h0;
        conn_d = 4'h0;
        if (rx_valid_i && c == slp_pkg::CH_STX) begin
          tmr_load = 1'b1;
          tmr_ms = slp_pkg::BUF_WAIT_MS;
          state_d = rxfull_q ? slp_pkg::S_RX_BUF : slp_pkg::S_RX_DLE;
        end else if (rx_valid_i && c != slp_pkg::CH_NAK) begin
          tmr_load = 1'b1;
          tmr_ms = cfg0_q[31:16];
          state_d = slp_pkg::S_IDLE_GAP;
        end else if (job_q) begin
          state_d = slp_pkg::S_TX_STX;
        end
      end
      slp_pkg::S_IDLE_GAP: if (tmo) begin
        err_code = slp_pkg::ERR_IDLE_CHAR;
        state_d = slp_pkg::S_NAK_END;
      end
      slp_pkg::S_TX_STX: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_STX;
        bcc_d = 8'h0;
        idx_d = '0;
        tmr_load = 1'b1;
        tmr_ms = cfg_q.ack_ms;
        state_d = slp_pkg::S_TX_CONN;
      end
      slp_pkg::S_TX_CONN: begin
        if (rx_valid_i && c == slp_pkg::CH_DLE && !rx_err_i) begin
          state_d = slp_pkg::S_TX_DATA;
        end else if (rx_valid_i && c == slp_pkg::CH_STX && !cfg_q.hiprio) begin
          // yield; the job stays pending for after this connection
          rep_d = 4'h0;
          tmr_load = 1'b1;
          tmr_ms = slp_pkg::BUF_WAIT_MS;
          state_d = rxfull_q ? slp_pkg::S_RX_BUF : slp_pkg::S_RX_DLE;
        end else if ((rx_valid_i && c != slp_pkg::CH_STX) || tmo) begin
          if (conn_last) begin
            err_code = slp_pkg::ERR_CONN;
            job_clr = 1'b1;
            state_d = slp_pkg::S_NAK_END;
          end else begin
            conn_d = conn_q + 4'h1;
            state_d = slp_pkg::S_TX_STX;
          end
        end
      end
      slp_pkg::S_TX_DATA, slp_pkg::S_TX_DLE2, slp_pkg::S_TX_ETX, slp_pkg::S_TX_BCC: begin
        if (rx_valid_i) begin
          tmr_load = 1'b1;
          tmr_ms = cfg_q.gap_ms;
          state_d = slp_pkg::S_TX_GAP;
          if (c == slp_pkg::CH_NAK && !rx_err_i) begin
            if (rep_last) begin
              err_code = slp_pkg::ERR_TX_REP;
              job_clr = 1'b1;
              state_d = slp_pkg::S_NAK_END;
            end else begin
              rep_d = rep_q + 4'h1;
              state_d = slp_pkg::S_TX_STX;
            end
          end
        end else if (!txp_q) begin
          txp_d = 1'b1;
          unique case (state_q)
            slp_pkg::S_TX_DATA: begin
              if (idx_q == IW'(cfg1_q[15:8]) || idx_q == IDX_FULL) begin
                txd_d = slp_pkg::CH_DLE;
                state_d = slp_pkg::S_TX_ETX;
              end else begin
                txd_d = tx_byte;
                idx_d = idx_q + IW'(1);
                if (tx_byte == slp_pkg::CH_DLE) state_d = slp_pkg::S_TX_DLE2;
              end
            end
            slp_pkg::S_TX_DLE2: begin
              txd_d = slp_pkg::CH_DLE;
              state_d = slp_pkg::S_TX_DATA;
            end
            slp_pkg::S_TX_ETX: begin
              txd_d = slp_pkg::CH_ETX;
              tmr_load = !cfg_q.chk;
              tmr_ms = cfg_q.ack_ms;
              state_d = cfg_q.chk ? slp_pkg::S_TX_BCC : slp_pkg::S_TX_ACK;
            end
            default: begin
              txd_d = bcc_q;
              tmr_load = 1'b1;
              tmr_ms = cfg_q.ack_ms;
              state_d = slp_pkg::S_TX_ACK;
            end
          endcase
          if (state_q != slp_pkg::S_TX_BCC) bcc_d = bcc_q ^ txd_d;
        end
      end
      slp_pkg::S_TX_ACK: begin
        if (rx_valid_i && c == slp_pkg::CH_DLE && !rx_err_i) begin
          done_set = 1'b1;
          job_clr = 1'b1;
          state_d = slp_pkg::S_IDLE;
        end else if (rx_valid_i || tmo) begin
          if (rep_last) begin
            err_code = slp_pkg::ERR_TX_REP;
            job_clr = 1'b1;
            state_d = slp_pkg::S_NAK_END;
          end else begin
            rep_d = rep_q + 4'h1;
            state_d = slp_pkg::S_TX_STX;
          end
        end
      end
      slp_pkg::S_TX_GAP: begin
        if (rx_valid_i) tmr_load = 1'b1;
        else if (tmo) begin
          if (rep_last) begin
            err_code = slp_pkg::ERR_TX_REP;
            job_clr = 1'b1;
            state_d = slp_pkg::S_NAK_END;
          end else begin
            rep_d = rep_q + 4'h1;
            state_d = slp_pkg::S_NAK_RETRY;
          end
        end
      end
      slp_pkg::S_NAK_RETRY, slp_pkg::S_NAK_END: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_NAK;
        state_d = (state_q == slp_pkg::S_NAK_RETRY) ? slp_pkg::S_TX_STX : slp_pkg::S_IDLE;
      end
      slp_pkg::S_RX_BUF: begin
        if (!rxfull_q) state_d = slp_pkg::S_RX_DLE;
        else if (tmo) begin
          err_code = slp_pkg::ERR_NOBUF;
          state_d = slp_pkg::S_NAK_END;
        end
      end
      slp_pkg::S_RX_DLE: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_DLE;
        idx_d = '0;
        bcc_d = 8'h0;
        bad_d = 1'b0;
        dle_d = 1'b0;
        tmr_load = 1'b1;
        state_d = slp_pkg::S_RX_DATA;
      end
      slp_pkg::S_RX_DATA: begin
        if (rx_valid_i) begin
          tmr_load = 1'b1;
          bcc_d = bcc_q ^ c;
          if (rx_err_i) bad_d = 1'b1;
          if (dle_q && c == slp_pkg::CH_ETX) begin
            dle_d = 1'b0;
            if (cfg_q.chk) state_d = slp_pkg::S_RX_CHK;
            else state_d = (bad_q || rx_err_i) ? slp_pkg::S_RX_NAK : slp_pkg::S_RX_ACK;
          end else if (c == slp_pkg::CH_DLE && !dle_q) begin
            dle_d = 1'b1;
          end else begin
            dle_d = 1'b0;
            if (dle_q && c != slp_pkg::CH_DLE) bad_d = 1'b1;
            if (idx_q == IDX_FULL) begin
              err_code = slp_pkg::ERR_RX_OVF;
              state_d = slp_pkg::S_NAK_END;
            end else begin
              rx_we = 1'b1;
              idx_d = idx_q + IW'(1);
            end
          end
        end else if (tmo) begin
          err_code = slp_pkg::ERR_RX_GAP;
          state_d = slp_pkg::S_NAK_END;
        end
      end
      slp_pkg::S_RX_CHK: begin
        if (rx_valid_i) begin
          if (c == bcc_q && !bad_q && !rx_err_i) state_d = slp_pkg::S_RX_ACK;
          else state_d = slp_pkg::S_RX_NAK;
        end else if (tmo) begin
          err_code = slp_pkg::ERR_RX_GAP;
          state_d = slp_pkg::S_NAK_END;
        end
      end
      slp_pkg::S_RX_ACK: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_DLE;
        rxfull_set = 1'b1;
        state_d = slp_pkg::S_IDLE;
      end
      slp_pkg::S_RX_NAK: if (!txp_q) begin
        txp_d = 1'b1;
        txd_d = slp_pkg::CH_NAK;
        tmr_load = 1'b1;
        tmr_ms = slp_pkg::REPEAT_WAIT_MS;
        if (rep_last) begin
          err_code = slp_pkg::ERR_RX_REP;
          state_d = slp_pkg::S_IDLE;
        end else begin
          rep_d = rep_q + 4'h1;
          state_d = slp_pkg::S_RX_REP;
        end
      end
      slp_pkg::S_RX_REP: begin
        if (rx_valid_i && c == slp_pkg::CH_STX) state_d = slp_pkg::S_RX_DLE;
        else if (tmo) begin
          err_code = slp_pkg::ERR_NO_REPEAT;
          state_d = slp_pkg::S_IDLE;
        end
      end
      default: state_d = slp_pkg::S_IDLE;
    endcase
  end

  // framing bits are added by the serializer behind tx_data_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= slp_pkg::S_RST_NAK;
      cfg_q <= '0;
      txd_q <= 8'h0;
      txp_q <= 1'b0;
      bcc_q <= 8'h0;
      bad_q <= 1'b0;
      dle_q <= 1'b0;
      idx_q <= '0;
      conn_q <= 4'h0;
      rep_q <= 4'h0;
      rlen_q <= 8'h0;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      txd_q <= txd_d;
      txp_q <= txp_d;
      bcc_q <= bcc_d;
      bad_q <= bad_d;
      dle_q <= dle_d;
      idx_q <= idx_d;
      conn_q <= conn_d;
      rep_q <= rep_d;
      if (rxfull_set) rlen_q <= 8'(idx_q);
    end
  end
endmodule
`default_nettype wire

//--- hw/slp_ms_tick.sv
// one-cycle millisecond tick from the system clock
`default_nettype none
module slp_ms_tick #(
  parameter int CYC_PER_MS = slp_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // tick out
  output logic      tick_o
);
  localparam logic [31:0] LAST = 32'(CYC_PER_MS - 1);
  logic [31:0] cnt_q;

  assign tick_o = (cnt_q == LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || tick_o) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h1;
  end
endmodule
`default_nettype wire

//--- hw/slp_ms_timer.sv
// millisecond down counter with restart and expiry flag
`default_nettype none
module slp_ms_timer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        tick_i,
  input  wire logic        load_i,
  input  wire logic [15:0] ms_i,
  // state
  output logic             expired_o
);
  logic [15:0] cnt_q;
  logic        run_q;

  // resolution is one tick, so a wait may end up to 1 ms early
  assign expired_o = run_q && (cnt_q == 16'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0;
      run_q <= 1'b0;
    end else if (load_i) begin
      cnt_q <= ms_i;
      run_q <= 1'b1;
    end else if (tick_i && cnt_q != 16'h0) begin
      cnt_q <= cnt_q - 16'h1;
    end
  end
endmodule
`default_nettype wire

//--- hw/slp_pkg.sv
// constants, types and register map of the serial link procedure controller
`default_nettype none
package slp_pkg;
  // control characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_DLE = 8'h10;
  localparam logic [7:0] CH_NAK = 8'h15;
  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CFG0 = 8'h04;
  localparam logic [7:0] ADR_CFG1 = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam logic [1:0] BANK_TXBUF = 2'h1;
  localparam logic [1:0] BANK_RXBUF = 2'h2;
  // control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_CHK = 1;
  localparam int CTRL_HIPRIO = 2;
  localparam int CTRL_RXREL = 3;
  localparam int CTRL_ERRCLR = 4;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_RXFULL = 2;
  localparam int STAT_ERR_LSB = 8;
  localparam int STAT_RLEN_LSB = 16;
  // reset values of the configuration
  localparam logic [15:0] RST_ACK_MS = 16'h07d0;
  localparam logic [15:0] RST_GAP_MS = 16'h00dc;
  localparam logic [3:0] RST_ATTEMPTS = 4'h6;
  localparam logic [3:0] RST_REPEATS = 4'h6;
  // error codes in the status report word
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CONN = 8'h01;
  localparam logic [7:0] ERR_TX_REP = 8'h02;
  localparam logic [7:0] ERR_IDLE_CHAR = 8'h03;
  localparam logic [7:0] ERR_RX_OVF = 8'h04;
  localparam logic [7:0] ERR_RX_GAP = 8'h05;
  localparam logic [7:0] ERR_RX_REP = 8'h06;
  localparam logic [7:0] ERR_NOBUF = 8'h07;
  localparam logic [7:0] ERR_NO_REPEAT = 8'h08;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] BUF_WAIT_MS = 16'd400;
  localparam logic [15:0] REPEAT_WAIT_MS = 16'd4000;

  typedef struct packed {
    logic [15:0] ack_ms;
    logic [15:0] gap_ms;
    logic [3:0]  attempts;
    logic [3:0]  repeats;
    logic        chk;
    logic        hiprio;
  } slp_cfg_s;

  typedef enum logic [4:0] {
    S_RST_NAK  = 5'h00, S_IDLE    = 5'h01, S_IDLE_GAP = 5'h02,
    S_TX_STX   = 5'h03, S_TX_CONN = 5'h04, S_TX_DATA  = 5'h05,
    S_TX_DLE2  = 5'h06, S_TX_ETX  = 5'h07, S_TX_BCC   = 5'h08,
    S_TX_ACK   = 5'h09, S_TX_GAP  = 5'h0a, S_NAK_RETRY = 5'h0b,
    S_NAK_END  = 5'h0c, S_RX_BUF  = 5'h0d, S_RX_DLE   = 5'h0e,
    S_RX_DATA  = 5'h0f, S_RX_CHK  = 5'h10, S_RX_ACK   = 5'h11,
    S_RX_NAK   = 5'h12, S_RX_REP  = 5'h13
  } slp_state_e;
endpackage
`default_nettype wire
